// [panel_ctrl.sv]
// Panel driver control: registers, frame timing, blink phase and frame request
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module panel_ctrl #(
  parameter int COLS = 16
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Register port
  input  wire panel_pkg::bus_req_t   bus,
  output logic [7:0]                 rdata,
  // Time sources and chip mode
  input  wire logic                  tb_tick,
  input  wire logic                  sub_tick,
  input  wire logic [1:0]            clock_mode,
  // Panel side
  output panel_pkg::panel_ctl_t      ctl,
  output logic [COLS-1:0]            column_drive_enable,
  output logic [7:0]                 backplane_line,
  output logic [15:0]                blink_select_bits,
  output logic                       blink_off_phase,
  output logic                       frame_irq
);

  // Two 8-bit column enable registers serve exactly sixteen columns
  if (COLS != 16) begin : g_cols_check
    $error("COLS must be 16 for the two column enable registers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] prim;
    logic [7:0] sec;
    logic [7:0] col_mid;
    logic [7:0] col_top;
    logic [7:0] blink_lo;
    logic [7:0] blink_hi;
    logic       blink_iv;
    logic [7:0] tick_cnt;
    logic [2:0] line;
    logic [7:0] blink_cnt;
    logic       blink_off;
    logic [7:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic       src_tick;
  logic       src_ok;
  logic       run;
  logic [7:0] frame_len;
  logic [2:0] last_line;
  logic       frame_end;
  logic       eight;

  ////////////////////////////////////////////////////////////////////////////
  // Run conditions and tick selection
  always_comb begin
    // Main time-base tick already runs off an ungeared divider, so gear is invisible here
    src_tick = s_q.prim[7] ? sub_tick : tb_tick;                             // see RULE1, RULE3
    src_ok   = s_q.prim[7] || (clock_mode == panel_pkg::CMODE_MAIN_RUN);      // see RULE2
    run      = (s_q.prim[4:2] != panel_pkg::MODE_OFF) && src_ok              // see RULE9
               && ((clock_mode != panel_pkg::CMODE_MAIN_STOP && clock_mode != panel_pkg::CMODE_WATCH)
                   || s_q.prim[6]);                                           // see RULE4
    eight    = s_q.prim[4];                                                   // see RULE8
    last_line = eight ? 3'h7 : 3'h3;
    case (s_q.prim[1:0])                                                      // see RULE12
      2'h0:    frame_len = panel_pkg::FRAME_TICKS_0;
      2'h1:    frame_len = panel_pkg::FRAME_TICKS_1;
      2'h2:    frame_len = panel_pkg::FRAME_TICKS_2;
      default: frame_len = panel_pkg::FRAME_TICKS_3;
    endcase
    frame_end = run && src_tick && (s_q.tick_cnt == frame_len - 8'h01)
                && (s_q.line == last_line);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    // Frame and backplane stepping
    if (!run) begin
      s_d.tick_cnt = 8'h00;
      s_d.line     = 3'h0;
    end else if (src_tick) begin
      if (s_q.tick_cnt == frame_len - 8'h01) begin
        s_d.tick_cnt = 8'h00;
        s_d.line     = (s_q.line == last_line) ? 3'h0 : s_q.line + 3'h1;
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 8'h01;
      end
    end
    // Blink phase runs from the subclock prescaler
    if (sub_tick) begin
      if (s_q.blink_cnt >= (s_q.blink_iv ? panel_pkg::BLINK_HALF_LONG : panel_pkg::BLINK_HALF_SHORT)
                           - 8'h01) begin                                     // see RULE22
        s_d.blink_cnt = 8'h00;
        s_d.blink_off = ~s_q.blink_off;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 8'h01;
      end
    end
    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        panel_pkg::ADDR_CTRL_PRIMARY:  s_d.prim = bus.wdata;                 // see RULE6, RULE13
        panel_pkg::ADDR_CTRL_SECONDARY: begin
          s_d.sec[7:1] = bus.wdata[7:1] & panel_pkg::SEC_WR_MASK[7:1];       // see RULE20
          if (!bus.wdata[panel_pkg::SEC_FLAG_BIT])
            s_d.sec[0] = 1'b0;                                               // see RULE18
        end
        panel_pkg::ADDR_COL_EN_HI_MID: s_d.col_mid  = bus.wdata;             // see RULE21
        panel_pkg::ADDR_COL_EN_TOP:    s_d.col_top  = bus.wdata;
        panel_pkg::ADDR_BLINK_LOW:     s_d.blink_lo = bus.wdata;
        panel_pkg::ADDR_BLINK_HIGH:    s_d.blink_hi = bus.wdata;
        panel_pkg::ADDR_STATUS:        s_d.blink_iv = bus.wdata[0];
        default: ;
      endcase
    end
    // Frame end sets the flag and wins over a clearing write
    if (frame_end)
      s_d.sec[0] = 1'b1;                                                      // see RULE18
    // Read data, one cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        panel_pkg::ADDR_CTRL_PRIMARY:   s_d.rdata = s_q.prim;
        panel_pkg::ADDR_CTRL_SECONDARY: s_d.rdata = {2'b00, s_q.sec[5:1],    // see RULE20
                                                     s_q.sec[0] | bus.rmw};  // see RULE19
        panel_pkg::ADDR_COL_EN_HI_MID:  s_d.rdata = s_q.col_mid;
        panel_pkg::ADDR_COL_EN_TOP:     s_d.rdata = s_q.col_top;
        panel_pkg::ADDR_BLINK_LOW:      s_d.rdata = s_q.blink_lo;
        panel_pkg::ADDR_BLINK_HIGH:     s_d.rdata = s_q.blink_hi;
        panel_pkg::ADDR_STATUS:         s_d.rdata = {s_q.line, s_q.blink_off, 2'b00, run, s_q.blink_iv};
        default:                        s_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.prim     <= panel_pkg::RST_CTRL_PRIMARY;
      s_q.sec      <= panel_pkg::RST_CTRL_SECONDARY;
      s_q.col_mid  <= panel_pkg::RST_COL_EN;
      s_q.col_top  <= panel_pkg::RST_COL_EN;
      s_q.blink_lo <= panel_pkg::RST_BLINK;
      s_q.blink_hi <= panel_pkg::RST_BLINK;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_bp
      // Only the lines inside the chosen four or eight backplanes are driven
      assign backplane_line[g] = run && (s_q.line == 3'(g)) && (3'(g) <= last_line); // see RULE8
    end
  endgenerate

  always_comb begin
    ctl.ladder_on    = s_q.prim[5];                                           // see RULE6
    ctl.res_10k      = s_q.sec[panel_pkg::SEC_RES_BIT];                       // see RULE13
    ctl.bias_quarter = eight & s_q.sec[panel_pkg::SEC_BIAS_BIT];              // see RULE14
    ctl.eight_lines  = eight;
    ctl.duty         = s_q.prim[3:2];
    ctl.negate       = s_q.sec[panel_pkg::SEC_NEG_BIT];                       // see RULE15
    ctl.blank_cols   = s_q.sec[panel_pkg::SEC_BLK_BIT];                       // see RULE16
    ctl.running      = run;
  end

  assign column_drive_enable = {s_q.col_top, s_q.col_mid};
  assign blink_select_bits   = {s_q.blink_hi, s_q.blink_lo};
  assign blink_off_phase     = s_q.blink_off;
  assign rdata               = s_q.rdata;
  // Level request, not a pulse, so a late enable still raises it
  assign frame_irq = s_q.sec[panel_pkg::SEC_FLAG_BIT] & s_q.sec[panel_pkg::SEC_IEN_BIT]; // see RULE23, RULE17

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  irq_follows_a: assert property (@(posedge clock) disable iff (rst)  // see RULE23
    frame_end && s_q.sec[1] && !(bus.wr && bus.addr == panel_pkg::ADDR_CTRL_SECONDARY)
    |=> frame_irq) else $error("irq not raised at frame end");
  flag_sets_a: assert property (@(posedge clock) disable iff (rst)  // see RULE18
    frame_end |=> s_q.sec[0]) else $error("flag not set at frame end");
  flag_clear_a: assert property (@(posedge clock) disable iff (rst)  // see RULE18
    bus.wr && bus.addr == panel_pkg::ADDR_CTRL_SECONDARY && !bus.wdata[0] && !frame_end
    |=> !s_q.sec[0]) else $error("flag not cleared");
  rmw_one_a: assert property (@(posedge clock) disable iff (rst)  // see RULE19
    bus.rd && bus.rmw && bus.addr == panel_pkg::ADDR_CTRL_SECONDARY |=> rdata[0])
    else $error("rmw read gave 0");
  top_zero_a: assert property (@(posedge clock) disable iff (rst)  // see RULE20
    bus.rd && bus.addr == panel_pkg::ADDR_CTRL_SECONDARY |=> rdata[7:6] == 2'b00)
    else $error("top bits nonzero");
  off_stops_a: assert property (@(posedge clock) disable iff (rst)  // see RULE9
    s_q.prim[4:2] == 3'h0 |-> backplane_line == 8'h00 && !ctl.running)
    else $error("display runs in off mode");
  low_power_a: assert property (@(posedge clock) disable iff (rst)  // see RULE4
    (clock_mode == panel_pkg::CMODE_WATCH && !s_q.prim[6]) |-> !ctl.running)
    else $error("runs in watch without enable");
  main_src_a: assert property (@(posedge clock) disable iff (rst)  // see RULE2
    (clock_mode == panel_pkg::CMODE_SUBCLOCK && !s_q.prim[7]) |-> !ctl.running)
    else $error("main source used in subclock mode");
  bias_four_a: assert property (@(posedge clock) disable iff (rst)  // see RULE14
    !eight |-> !ctl.bias_quarter) else $error("bias applied in four-line mode");
  irq_masked_a: assert property (@(posedge clock) disable iff (rst)  // see RULE17
    !s_q.sec[1] |=> !frame_irq || $past(bus.wr)) else $error("irq not masked");

  frame_seen_c:  cover property (@(posedge clock) disable iff (rst) frame_end);
  irq_seen_c:    cover property (@(posedge clock) disable iff (rst) $rose(frame_irq));
  eight_run_c:   cover property (@(posedge clock) disable iff (rst) run && eight);
  blink_flip_c:  cover property (@(posedge clock) disable iff (rst) $rose(blink_off_phase));

endmodule : panel_ctrl

// [panel_pkg.sv]
// Constants, register map and carrier types for the panel driver control block
// Notes on behaviour
// RULE1: source bit 0 uses main time-base tick, 1 uses subclock prescaler tick
// RULE2: main time-base tick is unusable in main stop and subclock modes
// RULE3: main clock gear changes never alter the frame period
// RULE4: run enable 0 stops driver in main stop or watch; 1 keeps running
// RULE5: software picks subclock source before running through low-power modes
// RULE6: ladder power bit 0 de-energises internal divider, 1 energises it
// RULE7: software keeps ladder power off when an external divider is fitted
// RULE8: three-bit mode picks four or eight backplanes and one of four duties
// RULE9: mode field all zeros stops display operation entirely
// RULE10: software stops display before the chosen frame clock may halt
// RULE11: software blanks display before changing mode, period or clock speed
// RULE12: two-bit period select picks one of four frame periods
// RULE13: resistance choice 0 selects 100 kilo-ohm, 1 selects 10 kilo-ohm ladder
// RULE14: eight-line bias 0 is one-third, 1 one-quarter; ignored in four-line mode
// RULE15: negate bit 1 inverts displayed contents, 0 shows them plain
// RULE16: blanking 1 drives every column with the non-selected waveform
// RULE17: irq enable 1 lets frame request out, 0 suppresses it
// RULE18: done flag set at frame end; writing 0 clears, writing 1 no effect
// RULE19: read-modify-write read of done flag always returns 1
// RULE20: top two bits of second control register read 0, ignore writes
// RULE21: each column enable bit makes its pin a column output
// RULE22: blink interval 1.0 s gives 0.5 s phases, 0.5 s gives 0.25 s
// RULE23: irq output high exactly while done flag and irq enable are both 1
package panel_pkg;

  // Register addresses
  localparam logic [11:0] ADDR_CTRL_PRIMARY   = 12'hfb0;
  localparam logic [11:0] ADDR_CTRL_SECONDARY = 12'h04f;
  localparam logic [11:0] ADDR_COL_EN_HI_MID  = 12'hfb6;
  localparam logic [11:0] ADDR_COL_EN_TOP     = 12'hfb7;
  localparam logic [11:0] ADDR_BLINK_LOW      = 12'hfb9;
  localparam logic [11:0] ADDR_BLINK_HIGH     = 12'hfba;
  localparam logic [11:0] ADDR_STATUS         = 12'hfbf;

  // Reset values
  localparam logic [7:0] RST_CTRL_PRIMARY   = 8'h00;
  localparam logic [7:0] RST_CTRL_SECONDARY = 8'h14;
  localparam logic [7:0] RST_COL_EN         = 8'h00;
  localparam logic [7:0] RST_BLINK          = 8'h00;

  // Field positions, second control register
  localparam int SEC_RES_BIT  = 5;
  localparam int SEC_BIAS_BIT = 4;
  localparam int SEC_NEG_BIT  = 3;
  localparam int SEC_BLK_BIT  = 2;
  localparam int SEC_IEN_BIT  = 1;
  localparam int SEC_FLAG_BIT = 0;
  localparam logic [7:0] SEC_WR_MASK = 8'h3e;

  // Mode field: 1..3 four-backplane, 4..7 eight-backplane
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam int         MODE_EIGHT_BIT = 2;

  // Frame timing in source ticks per backplane line for each period choice
  localparam logic [7:0] FRAME_TICKS_0 = 8'h10;
  localparam logic [7:0] FRAME_TICKS_1 = 8'h20;
  localparam logic [7:0] FRAME_TICKS_2 = 8'h40;
  localparam logic [7:0] FRAME_TICKS_3 = 8'h80;

  // Blink phase lengths in subclock prescaler ticks (prescaler tick rate 128 Hz assumed)
  localparam logic [7:0] BLINK_HALF_LONG  = 8'h40; // 0.5 s phase
  localparam logic [7:0] BLINK_HALF_SHORT = 8'h20; // 0.25 s phase

  // Chip clock modes seen by the driver
  localparam logic [1:0] CMODE_MAIN_RUN  = 2'h0;
  localparam logic [1:0] CMODE_SUBCLOCK  = 2'h1;
  localparam logic [1:0] CMODE_MAIN_STOP = 2'h2;
  localparam logic [1:0] CMODE_WATCH     = 2'h3;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        rmw;
  } bus_req_t;

  // Analog and waveform controls towards the panel output stage
  typedef struct packed {
    logic       ladder_on;
    logic       res_10k;
    logic       bias_quarter;
    logic       eight_lines;
    logic [1:0] duty;
    logic       negate;
    logic       blank_cols;
    logic       running;
  } panel_ctl_t;

endpackage : panel_pkg

// [panel_model.sv]
// Panel backplane side model: flags overlapping drive and counts line steps
`timescale 1ns/1ps
module panel_model (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Drive from the controller
  input  wire panel_pkg::panel_ctl_t ctl,
  input  wire logic [7:0]            backplane_line,
  // Tallies for the bench
  output int                         faults,
  output int                         steps
);
  logic [7:0] prev_q;
  ////////////////////////////////////////////////////////////////
  // Two driven backplanes would short on glass, so any overlap is a fault
  always @(posedge clock) begin
    if (rst) begin
      faults <= 0;
      steps  <= 0;
      prev_q <= 8'h00;
    end else begin
      if (ctl.running ? !$onehot(backplane_line) : (backplane_line != 8'h00)) faults <= faults + 1;
      else if (!ctl.eight_lines && backplane_line[7:4] != 4'h0) faults <= faults + 1;
      if (backplane_line != prev_q) steps <= steps + 1;
      prev_q <= backplane_line;
    end
  end
endmodule : panel_model

// [lcd_panel_driver_control_test.sv]
// Self-checking bench for the panel driver control block
`timescale 1ns/1ps
module lcd_panel_driver_control_test;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end
  localparam logic [11:0] PA = panel_pkg::ADDR_CTRL_PRIMARY;
  localparam logic [11:0] SA = panel_pkg::ADDR_CTRL_SECONDARY;
  localparam logic [11:0] CA = panel_pkg::ADDR_COL_EN_HI_MID;
  localparam logic [11:0] CB = panel_pkg::ADDR_COL_EN_TOP;
  localparam logic [11:0] BA = panel_pkg::ADDR_BLINK_LOW;
  localparam logic [11:0] BB = panel_pkg::ADDR_BLINK_HIGH;
  logic                  clock, rst, tb_tick, sub_tick, tb_en, sub_en, rd_seen, blink_off, frame_irq;
  logic [1:0]            clock_mode;
  logic [7:0]            rdata, backplane_line, prim, sec;
  logic [15:0]           col_en, blink_bits, cv, bv;
  logic [7:0]            expq[$];
  panel_pkg::bus_req_t   bus;
  panel_pkg::panel_ctl_t ctl, exp_ctl;
  int                    err_total, total_checks, faults, steps, c;
  ////////////////////////////////////////////////////////////////
  panel_ctrl #(.COLS(16)) dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .tb_tick(tb_tick),
    .sub_tick(sub_tick), .clock_mode(clock_mode), .ctl(ctl), .column_drive_enable(col_en),
    .backplane_line(backplane_line), .blink_select_bits(blink_bits), .blink_off_phase(blink_off),
    .frame_irq(frame_irq));
  panel_model panel (.clock(clock), .rst(rst), .ctl(ctl), .backplane_line(backplane_line),
    .faults(faults), .steps(steps));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Both time sources pulse every other cycle while enabled
  always @(posedge clock) begin
    tb_tick <= tb_en & ~tb_tick;
    sub_tick <= sub_en & ~sub_tick;
  end
  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) `CHK(rdata, expq.pop_front())
    rd_seen <= bus.rd & ~rst;
  end
  ////////////////////////////////////////////////////////////////
  // One bus cycle; strobes stay up until the next call replaces them
  task automatic op(input logic [11:0] a, input logic [7:0] d, input logic w, r, m);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: w, rd: r, rmw: m};
  endtask : op
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    op(a, d, 1'b1, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic m = 1'b0);
    expq.push_back(e);
    op(a, 8'h00, 1'b0, 1'b1, m);
  endtask : rd
  task automatic idle(input int n);
    op(12'h000, 8'h00, 1'b0, 1'b0, 1'b0);
    repeat (n) @(posedge clock);
  endtask : idle
  // Cycles from starting the display to the first frame request
  task automatic frame_len(input logic [7:0] p, input int e);
    wr(PA, 8'h00);
    wr(SA, 8'h02);
    wr(PA, p);
    idle(0);
    c = 0;
    while (frame_irq !== 1'b1 && c < 3000) begin
      @(posedge clock);
      c++;
    end
    if (c >= 3000) begin
      err_total++;
      print_verdict();
    end
    `CHK(c inside {[e - 8:e + 8]}, 1'b1)
  endtask : frame_len
  // First full blink half after an interval change
  task automatic gap(input int e);
    logic b;
    repeat (2) begin
      b = blink_off;
      c = 0;
      while (blink_off === b && c < 600) begin
        @(posedge clock);
        c++;
      end
      if (c >= 600) begin
        err_total++;
        print_verdict();
      end
    end
    `CHK(c inside {[e - 3:e + 3]}, 1'b1)
  endtask : gap
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    bus = '0;
    tb_en = 1'b0;
    sub_en = 1'b0;
    tb_tick = 1'b0;
    sub_tick = 1'b0;
    rd_seen = 1'b0;
    clock_mode = panel_pkg::CMODE_MAIN_RUN;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'h52d9));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // Reset images, then a hole that ignores writes
    rd(PA, 8'h00);
    rd(SA, 8'h14);
    rd(CB, 8'h00);
    rd(BB, 8'h00);
    wr(12'hfb8, 8'hff);
    rd(12'hfb8, 8'h00);
    // Random images with both time sources idle, so the flag stays clear
    for (int i = 0; i < 8; i++) begin
      prim = 8'($urandom());
      sec = 8'($urandom()) & 8'hfe;
      cv = 16'($urandom());
      bv = 16'($urandom());
      wr(PA, prim);
      wr(SA, sec);
      wr(CA, cv[7:0]);
      wr(CB, cv[15:8]);
      wr(BA, bv[7:0]);
      wr(BB, bv[15:8]);
      rd(PA, prim);
      rd(SA, {2'b00, sec[5:1], 1'b0});
      rd(SA, {2'b00, sec[5:1], 1'b1}, 1'b1);
      idle(1);
      exp_ctl = {prim[5], sec[5], sec[4] & prim[4], prim[4], prim[3:2], sec[3], sec[2], |prim[4:2]};
      `CHK(ctl, exp_ctl)
      `CHK(col_en, cv)
      `CHK(blink_bits, bv)
    end
    // Run state over clock modes, source and low-power enable
    for (int k = 0; k < 16; k++) begin
      clock_mode <= k[1:0];
      wr(PA, {k[2], k[3], 6'h04});
      idle(1);
      if (k[2] || k[1:0] != 2'h3) `CHK(ctl.running, !(!k[2] && ^k[1:0]) && !(!k[3] && k[1]))
    end
    clock_mode <= panel_pkg::CMODE_MAIN_RUN;
    tb_en <= 1'b1;
    for (int p = 0; p < 4; p++) frame_len({6'h01, p[1:0]}, 128 << p);
    frame_len(8'h14, 256);
    // Writing one keeps the flag, writing zero clears it
    wr(SA, 8'h01);
    idle(1);
    `CHK(frame_irq, 1'b0)
    rd(SA, 8'h01);
    wr(SA, 8'h03);
    idle(1);
    `CHK(frame_irq, 1'b1)
    wr(PA, 8'h00);
    wr(SA, 8'h02);
    rd(SA, 8'h02);
    idle(1);
    `CHK(frame_irq, 1'b0)
    // Only the subclock ticks now
    tb_en <= 1'b0;
    sub_en <= 1'b1;
    frame_len(8'h84, 128);
    wr(PA, 8'h00);
    wr(SA, 8'h02);
    wr(PA, 8'h04);
    idle(400);
    `CHK(frame_irq, 1'b0)
    // Blink halves for both intervals
    wr(PA, 8'h84);
    wr(panel_pkg::ADDR_STATUS, 8'h01);
    gap(128);
    wr(panel_pkg::ADDR_STATUS, 8'h00);
    gap(64);
    `CHK(faults, 0)
    `CHK(steps > 0, 1'b1)
    print_verdict();
  end
endmodule : lcd_panel_driver_control_test
